// File: rtl/capcmp_pkg.sv
package capcmp_pkg;

  // ---------------------------------------------------------------
  // Register addresses
  // ---------------------------------------------------------------
  localparam logic [7:0] module_mode_control_addr = 8'hda;
  localparam logic [7:0] compare_value_low_addr   = 8'he9;
  localparam logic [7:0] compare_value_high_addr  = 8'hea;
  localparam logic [7:0] counter_control_reg_addr = 8'hd8;

  // ---------------------------------------------------------------
  // Mode register fields
  // ---------------------------------------------------------------
  localparam int wide_pulse_width_select_bit = 7;
  localparam int compare_enable_bit          = 6;
  localparam int rise_capture_enable_bit     = 5;
  localparam int fall_capture_enable_bit     = 4;
  localparam int equal_flag_enable_bit       = 3;
  localparam int invert_on_equal_enable_bit  = 2;
  localparam int pulse_width_enable_bit      = 1;
  localparam int flag_irq_enable_bit         = 0;

  // Event flag position in the counter control register
  localparam int module0_event_flag_bit = 0;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [7:0]  mode_reset    = 8'h00;
  localparam logic [15:0] compare_reset = 16'h0000;
  localparam logic        pin_reset     = 1'h1;

endpackage : capcmp_pkg

// File: rtl/counter_array_capture_compare_module.sv
// Summary of operation
// R1 - Software timer: counter equals compare sets flag
// R2 - Flag set and enabled raises interrupt
// R3 - Flag stays set; software clears it
// R4 - Compare plus match enable gives timer mode
// R5 - Low compare byte write clears compare enable
// R6 - High compare byte write sets compare enable
// R7 - Software writes low byte before high
// R8 - Wide select picks 8-bit or 16-bit pulse
// R9 - Bit 6 enables equality comparator
// R10 - Bit 5 enables rising edge capture
// R11 - Bit 4 enables falling edge capture
// R12 - Bit 3: equality sets event flag
// R13 - Bit 2: equality inverts output pin
// R14 - Bits 2 and 1: frequency output mode
// R15 - Bit 1 drives pulse width output
// R16 - Bit 0 enables the flag interrupt
// R17 - Capture edge copies counter, sets flag
// R18 - Equality checked once per counter increment
`timescale 1ns/1ps

module counter_array_capture_compare_module (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // Special-function register port
  input  wire logic [7:0]  sfr_addr,
  input  wire logic [7:0]  sfr_wdata,
  input  wire logic        sfr_wr,
  input  wire logic        sfr_rd,
  output logic      [7:0]  sfr_rdata,
  // Shared counter
  input  wire logic [15:0] counter_value,
  input  wire logic        counter_tick,
  // Module pin
  input  wire logic        module_pin_in,
  output logic             module_output_pin,
  output logic             module_output_pin_oe,
  // Status
  output logic             module0_event_flag,
  output logic             irq
);

  logic [7:0]  mode_q;
  logic [15:0] cmp_q;
  logic        flag_q;
  logic        pin_q;
  logic        rise_pulse;
  logic        fall_pulse;
  logic        wr_low;
  logic        wr_high;
  logic        wr_mode;
  logic        wr_ctl;
  logic        equal_hit;
  logic        low_hit;
  logic        capture_hit;
  logic        freq_mode;
  logic        pwm_mode;
  logic        pwm_level;

  function automatic logic sel(input logic [7:0] a, input logic [7:0] want);
    sel = (a == want);
  endfunction : sel

  // ---------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------
  assign wr_low  = sfr_wr & sel(sfr_addr, capcmp_pkg::compare_value_low_addr);
  assign wr_high = sfr_wr & sel(sfr_addr, capcmp_pkg::compare_value_high_addr);
  assign wr_mode = sfr_wr & sel(sfr_addr, capcmp_pkg::module_mode_control_addr);
  assign wr_ctl  = sfr_wr & sel(sfr_addr, capcmp_pkg::counter_control_reg_addr);

  pin_edge_detect u_edge (
    .clk        (clk),
    .sys_rst    (sys_rst),
    .pin_in     (module_pin_in),
    .rise_pulse (rise_pulse),
    .fall_pulse (fall_pulse)
  );

  // ---------------------------------------------------------------
  // Match and capture events
  // ---------------------------------------------------------------
  // Sampled only on the tick so a held equality counts once
  assign equal_hit = counter_tick & mode_q[capcmp_pkg::compare_enable_bit] // R9 R18
                   & (counter_value == cmp_q); // R1
  assign low_hit   = counter_tick & mode_q[capcmp_pkg::compare_enable_bit]
                   & (counter_value[7:0] == cmp_q[7:0]);
  assign capture_hit = (rise_pulse & mode_q[capcmp_pkg::rise_capture_enable_bit]) // R10
                     | (fall_pulse & mode_q[capcmp_pkg::fall_capture_enable_bit]); // R11
  assign pwm_mode  = mode_q[capcmp_pkg::pulse_width_enable_bit];
  assign freq_mode = pwm_mode & mode_q[capcmp_pkg::invert_on_equal_enable_bit]; // R14

  // ---------------------------------------------------------------
  // Mode register
  // ---------------------------------------------------------------
  // Byte writes to the compare value gate the comparator so a half
  // loaded value cannot match; software must write low then high
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      mode_q <= capcmp_pkg::mode_reset;
    end else if (wr_mode) begin
      mode_q <= sfr_wdata;
    end else if (wr_low) begin
      mode_q[capcmp_pkg::compare_enable_bit] <= 1'h0; // R5 R7
    end else if (wr_high) begin
      mode_q[capcmp_pkg::compare_enable_bit] <= 1'h1; // R6 R7
    end
  end

  // ---------------------------------------------------------------
  // Compare / capture value
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cmp_q <= capcmp_pkg::compare_reset;
    end else if (capture_hit) begin
      cmp_q <= counter_value; // R17
    end else if (wr_low) begin
      cmp_q[7:0] <= sfr_wdata;
    end else if (wr_high) begin
      cmp_q[15:8] <= sfr_wdata;
    end else if (freq_mode && low_hit) begin
      cmp_q[7:0] <= cmp_q[7:0] + cmp_q[15:8];
    end
  end

  // ---------------------------------------------------------------
  // Event flag: hardware set wins over software clear
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      flag_q <= 1'h0;
    end else if ((equal_hit && mode_q[capcmp_pkg::equal_flag_enable_bit]) || capture_hit) begin
      flag_q <= 1'h1; // R4 R12 R17
    end else if (wr_ctl) begin
      flag_q <= sfr_wdata[capcmp_pkg::module0_event_flag_bit]; // R3
    end
  end

  assign module0_event_flag = flag_q;
  assign irq = flag_q & mode_q[capcmp_pkg::flag_irq_enable_bit]; // R2 R16

  // ---------------------------------------------------------------
  // Output pin
  // ---------------------------------------------------------------
  // Pulse level: high until the counter reaches the compare value
  assign pwm_level = mode_q[capcmp_pkg::wide_pulse_width_select_bit]
                   ? (counter_value < cmp_q) // R8
                   : (counter_value[7:0] < cmp_q[7:0]); // R8

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pin_q <= capcmp_pkg::pin_reset;
    end else if (freq_mode) begin
      if (low_hit) begin
        pin_q <= ~pin_q; // R14
      end
    end else if (pwm_mode) begin
      pin_q <= pwm_level; // R15
    end else if (equal_hit && mode_q[capcmp_pkg::invert_on_equal_enable_bit]) begin
      pin_q <= ~pin_q; // R13
    end
  end

  assign module_output_pin    = pin_q;
  assign module_output_pin_oe = pwm_mode | mode_q[capcmp_pkg::invert_on_equal_enable_bit];

  // ---------------------------------------------------------------
  // Read data, registered one cycle after the read strobe
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sfr_rdata <= 8'h00;
    end else if (sfr_rd) begin
      case (sfr_addr)
        capcmp_pkg::module_mode_control_addr: sfr_rdata <= mode_q;
        capcmp_pkg::compare_value_low_addr:   sfr_rdata <= cmp_q[7:0];
        capcmp_pkg::compare_value_high_addr:  sfr_rdata <= cmp_q[15:8];
        capcmp_pkg::counter_control_reg_addr: sfr_rdata <= {7'h00, flag_q};
        default:                              sfr_rdata <= 8'h00;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  timer_match_a: assert property ( // R1 R4
    mode_q[capcmp_pkg::compare_enable_bit] && mode_q[capcmp_pkg::equal_flag_enable_bit]
    && counter_tick && counter_value == cmp_q |=> flag_q)
    else $error("timer match did not set flag");
  irq_gate_a: assert property ( // R2
    irq == (flag_q && mode_q[capcmp_pkg::flag_irq_enable_bit]))
    else $error("irq not flag and enable");
  flag_hold_a: assert property ( // R3
    flag_q && !wr_ctl |=> flag_q) else $error("flag cleared without write");
  low_write_a: assert property ( // R5
    wr_low && !wr_mode |=> !mode_q[capcmp_pkg::compare_enable_bit])
    else $error("low write left compare on");
  high_write_a: assert property ( // R6
    wr_high && !wr_mode && !wr_low |=> mode_q[capcmp_pkg::compare_enable_bit])
    else $error("high write left compare off");
  no_compare_a: assert property ( // R9
    !mode_q[capcmp_pkg::compare_enable_bit] && !capture_hit && !flag_q && !wr_ctl |=> !flag_q)
    else $error("flag set with comparator off");
  capture_copy_a: assert property ( // R17
    capture_hit |=> cmp_q == $past(counter_value) && flag_q)
    else $error("capture did not copy counter");
  toggle_pin_a: assert property ( // R13
    equal_hit && mode_q[capcmp_pkg::invert_on_equal_enable_bit] && !pwm_mode
    |=> pin_q != $past(pin_q))
    else $error("pin not toggled on match");
  once_per_tick_a: assert property ( // R18
    !counter_tick && !capture_hit && !wr_ctl |=> flag_q == $past(flag_q))
    else $error("flag changed without tick");
  freq_toggle_a: assert property ( // R14
    freq_mode && low_hit |=> pin_q != $past(pin_q))
    else $error("pin not toggled in frequency mode");
  freq_step_a: assert property ( // R14
    freq_mode && low_hit && !capture_hit && !wr_low && !wr_high
    |=> cmp_q[7:0] == 8'($past(cmp_q[7:0]) + $past(cmp_q[15:8])))
    else $error("compare low byte not advanced");
  pwm_follow_a: assert property ( // R15
    pwm_mode && !freq_mode |=> pin_q == $past(pwm_level))
    else $error("pin does not follow pulse level");

  timer_event_c: cover property (equal_hit && mode_q[capcmp_pkg::equal_flag_enable_bit]
                                 ##1 flag_q);
  capture_rise_c: cover property (rise_pulse && mode_q[capcmp_pkg::rise_capture_enable_bit]);
  freq_toggle_c: cover property (freq_mode && low_hit);
  irq_raised_c: cover property (irq);

endmodule : counter_array_capture_compare_module

// File: rtl/pin_edge_detect.sv
`timescale 1ns/1ps

module pin_edge_detect (
  // Clock and reset
  input  wire logic clk,
  input  wire logic sys_rst,
  // Asynchronous pin level
  input  wire logic pin_in,
  // Edge pulses, one cycle each
  output logic      rise_pulse,
  output logic      fall_pulse
);

  logic meta_q;
  logic sync_q;
  logic last_q;

  // ---------------------------------------------------------------
  // Two-stage synchroniser; only sync_q reads meta_q
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      meta_q <= 1'h0;
      sync_q <= 1'h0;
      last_q <= 1'h0;
    end else begin
      meta_q <= pin_in;
      sync_q <= meta_q;
      last_q <= sync_q;
    end
  end

  assign rise_pulse = sync_q & ~last_q;
  assign fall_pulse = ~sync_q & last_q;

endmodule : pin_edge_detect

// File: test/counter_array_capture_compare_module_tb.sv
`timescale 1ns/1ps

module counter_array_capture_compare_module_tb;
  // -------------------------------------------------------------
  // Signals
  // -------------------------------------------------------------
  logic        clk;
  logic        sys_rst;
  logic [7:0]  sfr_addr;
  logic [7:0]  sfr_wdata;
  logic        sfr_wr;
  logic        sfr_rd;
  logic [7:0]  sfr_rdata;
  logic [15:0] counter_value;
  logic        counter_tick;
  logic        pin_drive;
  logic        pin_level;
  logic        out_pin;
  logic        out_oe;
  logic        flag;
  logic        irq;
  logic        p;
  int          bad_count;
  int          n_tests;

  counter_array_capture_compare_module i_counter_array_capture_compare_module (
    .clk(clk), .sys_rst(sys_rst), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
    .counter_value(counter_value), .counter_tick(counter_tick),
    .module_pin_in(pin_level), .module_output_pin(out_pin),
    .module_output_pin_oe(out_oe), .module0_event_flag(flag), .irq(irq));

  pin_partner i_pin_partner (
    .level_req(pin_drive), .mod_drive(out_pin), .mod_oe(out_oe), .pin_level(pin_level));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // -------------------------------------------------------------
  // Tasks
  // -------------------------------------------------------------
  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    sfr_wr    <= 1'b1;
    sfr_addr  <= a;
    sfr_wdata <= d;
    @(posedge clk);
    sfr_wr    <= 1'b0;
    // Let the write land before anyone looks at the outputs
    @(negedge clk);
  endtask : wr_reg

  task automatic rd_reg(input string name, input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    sfr_rd   <= 1'b1;
    sfr_addr <= a;
    @(posedge clk);
    sfr_rd   <= 1'b0;
    @(negedge clk);
    chk(name, {8'h00, sfr_rdata}, {8'h00, exp});
  endtask : rd_reg

  // One counter step; the result is sampled once that edge has landed
  task automatic tick(input logic [15:0] v);
    @(posedge clk);
    counter_value <= v;
    counter_tick  <= 1'b1;
    @(posedge clk);
    counter_tick  <= 1'b0;
    @(negedge clk);
  endtask : tick

  task automatic pin_to(input logic v);
    @(posedge clk);
    pin_drive <= v;
    repeat (8) @(negedge clk);
  endtask : pin_to

  task automatic wrap_up;
    if (bad_count == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : wrap_up

  initial begin
    #200000;
    bad_count++;
    wrap_up();
  end

  // -------------------------------------------------------------
  // Sequence
  // -------------------------------------------------------------
  initial begin
    bad_count = 0;
    n_tests = 0;
    sys_rst = 1'b1;
    sfr_addr = 8'h00;
    sfr_wdata = 8'h00;
    sfr_wr = 1'b0;
    sfr_rd = 1'b0;
    counter_value = 16'h0000;
    counter_tick = 1'b0;
    pin_drive = 1'b0;
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    @(negedge clk);
    chk("outputs", {12'h000, out_oe, out_pin, flag, irq}, 16'h0004);
    rd_reg("mode", 8'hda, 8'h00);
    rd_reg("unmapped", 8'h10, 8'h00);
    wr_reg(8'hda, 8'h49);
    wr_reg(8'he9, 8'h34);
    rd_reg("mode low", 8'hda, 8'h09);
    tick(16'h0034);
    chk("flag off", flag, 0);
    wr_reg(8'hea, 8'h12);
    rd_reg("mode high", 8'hda, 8'h49);
    tick(16'h1233);
    chk("flag miss", flag, 0);
    tick(16'h1234);
    chk("flag hit", flag, 1);
    chk("irq", irq, 1);
    wr_reg(8'hd8, 8'h00);
    repeat (3) @(negedge clk);
    chk("no tick", flag, 0);
    tick(16'h1234);
    repeat (20) @(negedge clk);
    chk("flag kept", flag, 1);
    wr_reg(8'hd8, 8'h00);
    wr_reg(8'hda, 8'h48);
    tick(16'h1234);
    chk("masked", {flag, irq}, 2'b10);
    wr_reg(8'hd8, 8'h00);
    wr_reg(8'hda, 8'h40);
    tick(16'h1234);
    chk("no match flag", flag, 0);
    wr_reg(8'hda, 8'h44);
    chk("oe", out_oe, 1);
    tick(16'h1234);
    chk("toggle 1", out_pin, 0);
    tick(16'h1234);
    chk("toggle 2", out_pin, 1);
    wr_reg(8'hda, 8'hc2);
    tick(16'h0050);
    chk("pwm wide", out_pin, 1);
    tick(16'h2000);
    chk("pwm wide off", out_pin, 0);
    wr_reg(8'hda, 8'h42);
    tick(16'h0050);
    chk("pwm narrow", out_pin, 0);
    wr_reg(8'hda, 8'h46);
    p = out_pin;
    tick(16'h0034);
    chk("freq pin", out_pin, {15'h0000, ~p});
    rd_reg("freq step", 8'he9, 8'h46);
    wr_reg(8'hda, 8'h20);
    wr_reg(8'hd8, 8'h00);
    tick(16'habcd);
    pin_to(1'b1);
    chk("rise cap", flag, 1);
    rd_reg("cap low", 8'he9, 8'hcd);
    rd_reg("cap high", 8'hea, 8'hab);
    wr_reg(8'hd8, 8'h00);
    pin_to(1'b0);
    chk("fall off", flag, 0);
    wr_reg(8'hda, 8'h10);
    tick(16'h5678);
    pin_to(1'b1);
    chk("rise off", flag, 0);
    pin_to(1'b0);
    chk("fall cap", flag, 1);
    rd_reg("cap fall", 8'he9, 8'h78);
    wrap_up();
  end
endmodule : counter_array_capture_compare_module_tb

// File: test/pin_partner.sv
`timescale 1ns/1ps

module pin_partner (
  // Far-side level request and module drive
  input  wire logic level_req,
  input  wire logic mod_drive,
  input  wire logic mod_oe,
  // Resolved pin level
  output logic      pin_level
);
  // -------------------------------------------------------------
  // Wire resolution
  // -------------------------------------------------------------
  // The module wins while it drives, so the far side never fights it
  assign pin_level = mod_oe ? mod_drive : level_req;
endmodule : pin_partner
